// >>> design/uasr_regs.sv
// Register bank of the micro-USB accessory switch, reached over a serial slave.
// Assumes analog status levels and strap arrive unsynchronised on pins.
//
// Functional notes
// - polarity bit 0 makes interrupt active low, 1 active high.
// - group A enable 0 masks all first status sources, 1 enables.
// - group B enable 0 masks all second status sources, 1 enables.
// - low-power bit 1 enables pulsed microphone power.
// - anti-click bit 1 connects suppression resistors on both audio pins.
// - bias bit 1 connects regulator to microphone through 200 k.
// - charger-type bit 1 enables charger type detection.
// - USB detect off bit 1 disables detection; resets 1, others 0.
// - mic path bit 1 connects microphone to ID line; resets 0.
// - plus select: 000 USB, 001 UART TX, 010 right audio, else open.
// - minus select: 000 USB, 001 UART RX, 010 left audio, else open.
// - selects reset open without VBUS, else follow the strap.
// - strap low or open picks USB paths, high picks UART paths.
// - charger-found bit reads 1 when a shorted dedicated charger is seen.
// - first removal bit mirrors comparator A; resets 0.
// - first button bit reads 1 when the ID line is grounded.
// - VBUS bit reads 1 while power is on VBUS.
// - four-bit ID code holds the ADC result; 1011 means open.
// - second status: bit 1 comparator B, bit 0 microphone line grounded.
// - dedicated charger bit reads 1 when such a charger is detected.
// - charging host bit reads 1 when a charging host port is seen.
// - contact timeout bit reads 1 after contact detection timed out.
// - burst writes increment address, wrapping from 14h back to 01h.
`timescale 1ns/1ps
`default_nettype none
`include "uasr_consts.svh"

module uasr_regs #(
  parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary identity value
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic int_pin_i,
  output logic int_pin_o,
  output logic int_pin_oe_n_o,
  input wire logic default_switch_strap_i,
  input wire logic vbus_present_i,
  input wire logic hc_charger_found_i,
  input wire logic mic_removal_cmp_a_i,
  input wire logic button_press_a_i,
  input wire logic [3:0] id_adc_code_i,
  input wire logic mic_removal_cmp_b_i,
  input wire logic button_press_b_i,
  input wire logic dedicated_charger_found_i,
  input wire logic charging_host_found_i,
  input wire logic contact_detect_timeout_i,
  output logic mic_pulse_low_power_o,
  output logic anti_click_enable_o,
  output logic mic_bias_connect_o,
  output logic charger_type_detect_en_o,
  output logic usb_detect_off_o,
  output logic mic_path_connect_o,
  output logic [2:0] plus_line_select_o,
  output logic [2:0] minus_line_select_o,
  output logic [2:0] plus_route_o,
  output logic [2:0] minus_route_o
);

  // ==========================================================
  // Input synchronisation
  logic [`UASR_NUM_IN-1:0] raw_in, syn;
  logic scl_s, sda_s, strap_s, vbus_s;
  logic [7:0] stat1, stat2, stat3;

  assign raw_in = {scl_i, sda_i, default_switch_strap_i, vbus_present_i, hc_charger_found_i,
                   mic_removal_cmp_a_i, button_press_a_i, id_adc_code_i, mic_removal_cmp_b_i,
                   button_press_b_i, dedicated_charger_found_i, charging_host_found_i,
                   contact_detect_timeout_i};

  uasr_sync #(
    .WIDTH(`UASR_NUM_IN)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  assign scl_s = syn[15];
  assign sda_s = syn[14];
  assign strap_s = syn[13];
  assign vbus_s = syn[12];
  // Status words are live views of settled pins; reset clears the synchronisers
  assign stat1 = {syn[11:9], vbus_s, syn[8:5]};
  assign stat2 = {6'h00, syn[4:3]};
  assign stat3 = {syn[2:1], 5'h00, syn[0]};

  // ==========================================================
  // Serial slave
  logic [7:0] ptr, rd_data, wr_data;
  logic wr, rd_done;

  uasr_i2c_slave u_i2c (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .sda_oe_n_o(sda_oe_n_o),
    .ptr_o(ptr),
    .rd_data_i(rd_data),
    .wr_o(wr),
    .wr_data_o(wr_data),
    .rd_done_o(rd_done)
  );

  assign sda_o = 1'b0;

  // ==========================================================
  // Control registers
  logic [7:0] ctl2_r, ctl2_nxt, sw_r, sw_nxt;
  logic [2:0] boot_r, boot_nxt;
  logic sw_written_r, sw_written_nxt;
  logic boot_load;

  assign boot_load = (boot_r == `UASR_BOOT_WAIT - 3'h1);

  always_comb begin
    ctl2_nxt = ctl2_r;
    sw_nxt = sw_r;
    boot_nxt = boot_r;
    sw_written_nxt = sw_written_r;
    if (boot_r != `UASR_BOOT_WAIT) begin
      boot_nxt = boot_r + 3'h1;
    end
    // Strap is taken once the synchronisers have settled, not in reset
    if (boot_load && !sw_written_r && vbus_s) begin
      sw_nxt[`UASR_SW_P_HI:`UASR_SW_P_LO] = strap_s ? `UASR_SEL_UART : `UASR_SEL_USB;
      sw_nxt[`UASR_SW_M_HI:`UASR_SW_M_LO] = strap_s ? `UASR_SEL_UART : `UASR_SEL_USB;
    end
    // Only the two control addresses store; others swallow the byte
    if (wr && ptr == `UASR_REG_CTL2) begin
      ctl2_nxt = wr_data;
    end
    if (wr && ptr == `UASR_REG_SW) begin
      sw_nxt = {1'b0, wr_data[6:0]};
      sw_written_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctl2_r <= `UASR_CTL2_RST;
      sw_r <= {2'b00, `UASR_SEL_OPEN, `UASR_SEL_OPEN};
      boot_r <= 3'h0;
      sw_written_r <= 1'b0;
    end else begin
      ctl2_r <= ctl2_nxt;
      sw_r <= sw_nxt;
      boot_r <= boot_nxt;
      sw_written_r <= sw_written_nxt;
    end
  end

  assign mic_pulse_low_power_o = ctl2_r[`UASR_CTL2_LP];
  assign anti_click_enable_o = ctl2_r[`UASR_CTL2_AC];
  assign mic_bias_connect_o = ctl2_r[`UASR_CTL2_MB];
  assign charger_type_detect_en_o = ctl2_r[`UASR_CTL2_CT];
  assign usb_detect_off_o = ctl2_r[`UASR_CTL2_UOFF];
  assign mic_path_connect_o = sw_r[`UASR_SW_MIC];
  assign plus_line_select_o = sw_r[`UASR_SW_P_HI:`UASR_SW_P_LO];
  assign minus_line_select_o = sw_r[`UASR_SW_M_HI:`UASR_SW_M_LO];

  // ==========================================================
  // Path decode: one-hot {audio, uart, usb}; reserved code left open for safety
  function automatic logic [2:0] route_of(input logic [2:0] sel);
    case (sel)
      `UASR_SEL_USB: route_of = 3'h1;
      `UASR_SEL_UART: route_of = 3'h2;
      `UASR_SEL_AUDIO: route_of = 3'h4;
      default: route_of = 3'h0;
    endcase
  endfunction

  assign plus_route_o = route_of(plus_line_select_o);
  assign minus_route_o = route_of(minus_line_select_o);

  // ==========================================================
  // Read mux
  always_comb begin
    case (ptr)
      `UASR_REG_ID: rd_data = DEVICE_ID;
      `UASR_REG_CTL2: rd_data = ctl2_r;
      `UASR_REG_SW: rd_data = sw_r;
      `UASR_REG_ST1: rd_data = stat1;
      `UASR_REG_ST2: rd_data = stat2;
      `UASR_REG_STAT: rd_data = stat3;
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Interrupt: sticky on change, cleared by reading the group, set wins
  logic [7:0] st1_q_r, st2_q_r;
  logic pend_a_r, pend_a_nxt, pend_b_r, pend_b_nxt;
  logic chg_a, chg_b, irq_active, irq_level;

  assign chg_a = ctl2_r[`UASR_CTL2_EN_A] && (stat1 != st1_q_r);
  assign chg_b = ctl2_r[`UASR_CTL2_EN_B] && (stat2 != st2_q_r);

  always_comb begin
    pend_a_nxt = pend_a_r;
    pend_b_nxt = pend_b_r;
    // Pointer has already stepped past the byte that was read
    if (rd_done && ptr == `UASR_REG_ST1 + 8'h01) begin
      pend_a_nxt = 1'b0;
    end
    if (rd_done && ptr == `UASR_REG_ST2 + 8'h01) begin
      pend_b_nxt = 1'b0;
    end
    if (chg_a) begin
      pend_a_nxt = 1'b1;
    end
    if (chg_b) begin
      pend_b_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st1_q_r <= 8'h00;
      st2_q_r <= 8'h00;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
    end else begin
      st1_q_r <= stat1;
      st2_q_r <= stat2;
      pend_a_r <= pend_a_nxt;
      pend_b_r <= pend_b_nxt;
    end
  end

  assign irq_active = (pend_a_r && ctl2_r[`UASR_CTL2_EN_A])
                    || (pend_b_r && ctl2_r[`UASR_CTL2_EN_B]);
  assign irq_level = ctl2_r[`UASR_CTL2_POL] ? irq_active : ~irq_active;
  // Open drain: a high level is only the pull-up, so we release for it
  assign int_pin_o = 1'b0;
  assign int_pin_oe_n_o = irq_level;

  // ==========================================================
  // Checks
  chk_irq_low_pol: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (irq_active && !ctl2_r[`UASR_CTL2_POL]) |-> !int_pin_oe_n_o)
    else $error("active-low interrupt not driven low");

  chk_irq_high_pol: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!irq_active && ctl2_r[`UASR_CTL2_POL]) |-> !int_pin_oe_n_o)
    else $error("idle active-high interrupt not held low");

  chk_group_a_mask: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!ctl2_r[`UASR_CTL2_EN_A] && !pend_b_r) |-> !irq_active)
    else $error("masked group A raised interrupt");

  chk_group_b_mask: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!ctl2_r[`UASR_CTL2_EN_B] && !pend_a_r) |-> !irq_active)
    else $error("masked group B raised interrupt");

  chk_change_raises: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (ctl2_r[`UASR_CTL2_EN_A] && stat1 != st1_q_r && $stable(ctl2_r)) |=> irq_active)
    else $error("status change did not raise interrupt");

  chk_ctl2_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr && ptr == `UASR_REG_CTL2) |=> (ctl2_r == $past(wr_data) && usb_detect_off_o == ctl2_r[0]))
    else $error("control two write not stored");

  chk_ro_ignored: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr && ptr != `UASR_REG_CTL2) |=> $stable(ctl2_r))
    else $error("write to other address changed control two");

  chk_ctl2_reset: assert property (@(posedge clk_sys_i)
    $fell(srst_i) |-> (ctl2_r == `UASR_CTL2_RST && !mic_path_connect_o))
    else $error("control reset values wrong");

  chk_open_no_vbus: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (boot_load && !sw_written_r && !vbus_s && !wr) |=> (plus_route_o == 3'h0 && minus_route_o == 3'h0))
    else $error("paths not open without vbus");

  chk_strap_uart: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (boot_load && !sw_written_r && vbus_s && strap_s && !wr) |=> (plus_route_o == 3'h2 && minus_route_o == 3'h2))
    else $error("pulled-up strap did not select uart paths");

  chk_plus_open: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    plus_line_select_o[2] |-> (plus_route_o == 3'h0))
    else $error("plus path not open for high codes");

  chk_minus_usb: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (minus_line_select_o == `UASR_SEL_USB) |-> (minus_route_o == 3'h1))
    else $error("minus path not on usb");

endmodule

`default_nettype wire

// >>> design/uasr_consts.svh
// Constants of the accessory switch register bank: addresses, fields, resets.
// Included by the design files by bare name; definitions only.
`ifndef UASR_CONSTS_SVH
`define UASR_CONSTS_SVH

// ==========================================================
// Serial port
`define UASR_SLAVE_ADDR 7'h44
`define UASR_NUM_IN 16

// ==========================================================
// Register addresses
`define UASR_REG_ID 8'h00
`define UASR_REG_CTL2 8'h02
`define UASR_REG_SW 8'h03
`define UASR_REG_ST1 8'h04
`define UASR_REG_ST2 8'h05
`define UASR_REG_STAT 8'h06
`define UASR_REG_FIRST 8'h01
`define UASR_REG_LAST 8'h14

// ==========================================================
// Control two fields and reset
`define UASR_CTL2_RST 8'h01
`define UASR_CTL2_POL 7
`define UASR_CTL2_EN_A 6
`define UASR_CTL2_LP 5
`define UASR_CTL2_AC 4
`define UASR_CTL2_MB 3
`define UASR_CTL2_EN_B 2
`define UASR_CTL2_CT 1
`define UASR_CTL2_UOFF 0

// ==========================================================
// Switch control fields and codes
`define UASR_SW_MIC 6
`define UASR_SW_P_HI 5
`define UASR_SW_P_LO 3
`define UASR_SW_M_HI 2
`define UASR_SW_M_LO 0
`define UASR_SEL_USB 3'h0
`define UASR_SEL_UART 3'h1
`define UASR_SEL_AUDIO 3'h2
`define UASR_SEL_OPEN 3'h7

// ==========================================================
// Start-up: edges to wait until the input synchronisers hold settled levels
`define UASR_BOOT_WAIT 3'h5

`endif

// >>> design/uasr_pkg.sv
// Types shared by the accessory switch register bank.
// Assumes the constants header is compiled alongside.
package uasr_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ADDR_END = 3'b010,
    I2C_ACK = 3'b011,
    I2C_REG = 3'b100,
    I2C_WDATA = 3'b101,
    I2C_RDATA = 3'b110,
    I2C_MACK = 3'b111
  } uasr_i2c_state_t;

endpackage

// >>> design/uasr_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module uasr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] ff1_r, ff2_r, ff3_r, q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (ff2_r[i] == ff3_r[i]) begin
        q_nxt[i] = ff3_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      q_r <= '0;
    end else begin
      ff1_r <= d_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule

`default_nettype wire

// >>> design/uasr_i2c_slave.sv
// Serial slave of the register bank: byte framing, pointer and strobes.
// Assumes scl and sda already synchronised; sda drive is active-low enable.
`timescale 1ns/1ps
`default_nettype none
`include "uasr_consts.svh"

module uasr_i2c_slave (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_n_o,
  output logic [7:0] ptr_o,
  input wire logic [7:0] rd_data_i,
  output logic wr_o,
  output logic [7:0] wr_data_o,
  output logic rd_done_o
);

  uasr_pkg::uasr_i2c_state_t st_r, st_nxt, next_r, next_nxt;
  logic scl_q_r, sda_q_r;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic rw_r, rw_nxt, pull_r, pull_nxt, wr_r, wr_nxt, rdd_r, rdd_nxt, isreg_r, isreg_nxt;
  logic rise, fall, start, stop;
  logic [7:0] ptr_inc;

  assign rise = scl_i & ~scl_q_r;
  assign fall = ~scl_i & scl_q_r;
  assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
  // Burst pointer wraps past the last register
  assign ptr_inc = (ptr_r == `UASR_REG_LAST) ? `UASR_REG_FIRST : ptr_r + 8'h01;

  always_comb begin
    st_nxt = st_r;
    next_nxt = next_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    rw_nxt = rw_r;
    pull_nxt = pull_r;
    wr_nxt = 1'b0;
    rdd_nxt = 1'b0;
    isreg_nxt = isreg_r;
    if (start) begin
      st_nxt = uasr_pkg::I2C_ADDR;
      cnt_nxt = 3'h0;
      pull_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = uasr_pkg::I2C_IDLE;
      pull_nxt = 1'b0;
    end else begin
      case (st_r)
        uasr_pkg::I2C_IDLE: begin
          pull_nxt = 1'b0;
        end
        uasr_pkg::I2C_ADDR, uasr_pkg::I2C_REG, uasr_pkg::I2C_WDATA: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_i};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              isreg_nxt = (st_r == uasr_pkg::I2C_REG);
              next_nxt = st_r;
              st_nxt = uasr_pkg::I2C_ADDR_END;
            end
          end
        end
        uasr_pkg::I2C_ADDR_END: begin
          if (fall) begin
            st_nxt = uasr_pkg::I2C_ACK;
            pull_nxt = 1'b1;
            if (next_r == uasr_pkg::I2C_ADDR) begin
              rw_nxt = sh_r[0];
              next_nxt = sh_r[0] ? uasr_pkg::I2C_RDATA : uasr_pkg::I2C_REG;
              if (sh_r[7:1] != `UASR_SLAVE_ADDR) begin
                st_nxt = uasr_pkg::I2C_IDLE;
                pull_nxt = 1'b0;
              end
            end else if (isreg_r) begin
              ptr_nxt = sh_r;
              next_nxt = uasr_pkg::I2C_WDATA;
            end else begin
              // Writes walk every address, read-only ones included
              wr_nxt = 1'b1;
              ptr_nxt = ptr_inc;
              next_nxt = uasr_pkg::I2C_WDATA;
            end
          end
        end
        uasr_pkg::I2C_ACK: begin
          if (fall) begin
            st_nxt = next_r;
            cnt_nxt = 3'h0;
            pull_nxt = 1'b0;
            if (next_r == uasr_pkg::I2C_RDATA) begin
              tx_nxt = rd_data_i;
              pull_nxt = ~rd_data_i[7];
            end
          end
        end
        uasr_pkg::I2C_RDATA: begin
          if (fall) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              pull_nxt = 1'b0;
              rdd_nxt = 1'b1;
              ptr_nxt = ptr_inc;
              st_nxt = uasr_pkg::I2C_MACK;
            end else begin
              pull_nxt = ~tx_r[3'h6 - cnt_r];
            end
          end
        end
        uasr_pkg::I2C_MACK: begin
          if (rise) begin
            next_nxt = uasr_pkg::I2C_RDATA;
            st_nxt = sda_i ? uasr_pkg::I2C_IDLE : uasr_pkg::I2C_ACK;
          end
        end
        default: begin
          st_nxt = uasr_pkg::I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= uasr_pkg::I2C_IDLE;
      next_r <= uasr_pkg::I2C_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 3'h0;
      rw_r <= 1'b0;
      pull_r <= 1'b0;
      wr_r <= 1'b0;
      rdd_r <= 1'b0;
      isreg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      next_r <= next_nxt;
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      rw_r <= rw_nxt;
      pull_r <= pull_nxt;
      wr_r <= wr_nxt;
      rdd_r <= rdd_nxt;
      isreg_r <= isreg_nxt;
    end
  end

  // Strobe carries the address it wrote, pointer has already moved on
  logic [7:0] wr_addr_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_addr_r <= 8'h00;
    end else begin
      wr_addr_r <= ptr_r;
    end
  end

  assign sda_oe_n_o = ~pull_r;
  assign ptr_o = wr_r ? wr_addr_r : ptr_r;
  assign wr_o = wr_r;
  assign wr_data_o = sh_r;
  assign rd_done_o = rdd_r;

  chk_burst_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_nxt && ptr_r == `UASR_REG_LAST) |=> (ptr_r == `UASR_REG_FIRST && wr_o))
    else $error("burst pointer did not wrap to first register");

endmodule

`default_nettype wire

// >>> test/uasr_i2c_master.sv
// Two-wire bus master model that stands in for the handset processor.
// Assumes open-drain lines with pull-ups; the bench resolves the wire levels.
`timescale 1ns/1ps
`default_nettype none

module uasr_i2c_master (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ==========================================================
  // Line phases
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Eight clocks a phase, above the slave's sync and agreement filter
  task automatic hp();
    repeat (8) @(negedge clk_sys_i);
  endtask

  task automatic start();
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
    hp();
  endtask

  // Ends a burst; the pointer only runs on until here
  task automatic stop();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask

  // ==========================================================
  // Bits and bytes
  // Data moves only mid low phase, never near an scl edge
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
    hp();
  endtask

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench of the accessory switch register bank.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic strap = 1'b0;
  logic vbus = 1'b0;
  logic hc = 1'b0;
  logic cmp_a = 1'b0;
  logic btn_a = 1'b0;
  logic cmp_b = 1'b0;
  logic btn_b = 1'b0;
  logic dcp = 1'b0;
  logic chp = 1'b0;
  logic cdto = 1'b0;
  logic [3:0] idc = 4'h0;
  logic scl, m_sda, sda_o, sda_oe_n, int_o, int_oe_n, lp, ac, mb, ct, uoff, micp;
  logic [2:0] psel, msel, proute, mroute;
  // Open-drain wires with pull-ups
  wire sda = m_sda & (sda_oe_n | sda_o);
  wire int_w = int_oe_n | int_o;
  int n_fail = 0;
  int n_tests = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  uasr_regs DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .int_pin_i(int_w), .int_pin_o(int_o),
    .int_pin_oe_n_o(int_oe_n), .default_switch_strap_i(strap), .vbus_present_i(vbus),
    .hc_charger_found_i(hc), .mic_removal_cmp_a_i(cmp_a), .button_press_a_i(btn_a),
    .id_adc_code_i(idc), .mic_removal_cmp_b_i(cmp_b), .button_press_b_i(btn_b),
    .dedicated_charger_found_i(dcp), .charging_host_found_i(chp),
    .contact_detect_timeout_i(cdto), .mic_pulse_low_power_o(lp), .anti_click_enable_o(ac),
    .mic_bias_connect_o(mb), .charger_type_detect_en_o(ct), .usb_detect_off_o(uoff),
    .mic_path_connect_o(micp), .plus_line_select_o(psel), .minus_line_select_o(msel),
    .plus_route_o(proute), .minus_route_o(mroute));

  uasr_i2c_master m (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tx(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    m.xfer(d, 1'b1, q, a);
    chk(a, 1'b0);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m.start();
    tx(8'h88);
    tx(p);
    tx(d);
    m.stop();
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic a;
    m.start();
    tx(8'h88);
    tx(p);
    m.start();
    tx(8'h89);
    m.xfer(8'hff, 1'b1, q, a);
    m.stop();
    chk(q, e);
  endtask

  task automatic do_reset();
    srst_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
  endtask

  task automatic settle();
    repeat (10) @(negedge clk_sys_i);
  endtask

  function automatic logic [2:0] rt(input logic [2:0] s);
    return (s == 3'h0) ? 3'h1 : (s == 3'h1) ? 3'h2 : (s == 3'h2) ? 3'h4 : 3'h0;
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(uoff, 1'b1);
    chk({micp, psel, msel}, 8'h3f);
    rd_chk(8'h02, 8'h01);
    rd_chk(8'h03, 8'h3f);
  endtask

  task automatic t_ctl2();
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 8'h01 << i;
      wr(8'h02, v);
      chk({lp, ac, mb, ct, uoff}, {v[5], v[4], v[3], v[1], v[0]});
      rd_chk(8'h02, v);
    end
  endtask

  task automatic t_sw();
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {1'b0, c[0], c[2:0], ~c[2:0]};
      wr(8'h03, v);
      chk({micp, psel, msel}, v);
      chk({proute, mroute}, {rt(v[5:3]), rt(v[2:0])});
      rd_chk(8'h03, v);
    end
  endtask

  task automatic t_status();
    {hc, cmp_a, btn_a, vbus, idc} = 8'hbb;
    {cmp_b, btn_b} = 2'b10;
    {dcp, chp, cdto} = 3'b101;
    settle();
    rd_chk(8'h04, 8'hbb);
    rd_chk(8'h05, 8'h02);
    rd_chk(8'h06, 8'h81);
    // Burst over the read-only registers must leave them alone
    m.start();
    tx(8'h88);
    tx(8'h04);
    tx(8'h00);
    tx(8'h00);
    tx(8'h00);
    m.stop();
    rd_chk(8'h04, 8'hbb);
    rd_chk(8'h06, 8'h81);
    // Burst from the top address wraps to 01h and runs on into the first writable one
    m.start();
    tx(8'h88);
    tx(8'h14);
    tx(8'h55);
    tx(8'h00);
    tx(8'h11);
    m.stop();
    rd_chk(8'h02, 8'h11);
  endtask

  task automatic t_irq();
    wr(8'h02, 8'h41);
    chk(int_w, 1'b1);
    hc = 1'b0;
    settle();
    chk(int_w, 1'b0);
    rd_chk(8'h04, 8'h3b);
    chk(int_w, 1'b1);
    wr(8'h02, 8'hc1);
    chk(int_w, 1'b0);
    btn_a = 1'b0;
    settle();
    chk(int_w, 1'b1);
    rd_chk(8'h04, 8'h1b);
    chk(int_w, 1'b0);
    wr(8'h02, 8'h01);
    btn_a = 1'b1;
    settle();
    chk(int_w, 1'b1);
    wr(8'h02, 8'h05);
    cmp_b = 1'b0;
    settle();
    chk(int_w, 1'b0);
    rd_chk(8'h05, 8'h00);
    chk(int_w, 1'b1);
  endtask

  task automatic t_strap();
    for (int s = 0; s < 2; s++) begin
      vbus = 1'b1;
      strap = s[0];
      do_reset();
      chk({psel, msel}, {3'(s), 3'(s)});
    end
    vbus = 1'b0;
    do_reset();
    chk({psel, msel}, 6'h3f);
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    do_reset();
    t_reset();
    t_ctl2();
    t_sw();
    t_status();
    t_irq();
    t_strap();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_fail++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
